// ---- pkg/fwo_pkg.sv ----
// constants shared by the flash write operation control block
// assumes a 32-bit avalon-mm register bus and a flash array with a level handshake
package fwo_pkg;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_SECT = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_DAT0 = 8'h0c;
  localparam logic [7:0] OFS_DAT1 = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam int CMD_LAUNCH = 15;
  localparam int CMD_PAUSE = 14;
  localparam int CMD_WPG = 13;
  localparam int CMD_DOUBLE_WORD_PROGRAM_SELECT = 12;
  localparam int CMD_SER = 11;
  localparam int CMD_MODULE_SELECT = 7;
  localparam int STAT_ERR = 8;
  localparam int STAT_PAUSE_REQUEST_PRG = 9;
  localparam int STAT_PAUSE_REQUEST_ERS = 10;
  localparam int ADDR_BANK_BIT = 17;
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [9:0] SECT_RST = 10'h000;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic [31:0] DAT_RST = 32'hffff_ffff;
  localparam logic [31:0] ODD_KEEP = 32'hffff_ffff;
  localparam logic [63:0] PRE_DATA = 64'h0000_0000_0000_0000;
  localparam logic [2:0] STEP_NONE = 3'h0;
  localparam logic [2:0] STEP_PRE = 3'h1;
  localparam logic [2:0] STEP_ERS = 3'h2;
  localparam logic [2:0] STEP_PRG = 3'h4;
  localparam logic [3:0] BANK0 = 4'h1;
  localparam logic [3:0] BANK1 = 4'h2;
  localparam logic [3:0] BANK2 = 4'h4;
  localparam logic [3:0] BANK3 = 4'h8;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN = 4'h2,
    ST_DRAIN = 4'h4,
    ST_SPARE = 4'h8
  } fwo_state_t;
endpackage

// ---- core/fwo_sync3.sv ----
// three-stage input synchroniser with agreement filter
// assumes the input is asynchronous to CLK_SYS
module fwo_sync3 (
  input wire logic clk,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic out_r;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      out_r <= 1'b0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        out_r <= s3_r;
    end
  end

  assign dout = out_r;
endmodule

// ---- core/fwo_sector_reg.sv ----
// sector selection and status bits for both flash modules
// assumes writes come only while no operation runs or is paused
module fwo_sector_reg (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr,
  input wire logic [9:0] wdata,
  input wire logic module_select,
  input wire logic clr,
  output logic [9:0] bank0_sector_bits,
  output logic [2:0] bank2_sector_bits,
  output logic [9:0] view
);
  logic [9:0] b0_r;
  logic [2:0] b2_r;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      b0_r <= fwo_pkg::SECT_RST;
      b2_r <= fwo_pkg::SECT_RST[2:0];
    end
    else if (clr)
    begin
      b0_r <= fwo_pkg::SECT_RST; // [R18]
      b2_r <= fwo_pkg::SECT_RST[2:0]; // [R18]
    end
    else if (wr && module_select)
      b0_r <= wdata; // [R16]
    else if (wr)
      b2_r <= wdata[2:0]; // [R16]
  end

  assign bank0_sector_bits = b0_r;
  assign bank2_sector_bits = b2_r;
  assign view = module_select ? b0_r : {7'h00, b2_r}; // [R16]
endmodule

// ---- core/fwo_ctrl.sv ----
// flash write operation control: command, suspend/resume and sector selection
// assumes an avalon-mm master with waitrequest and a flash array that answers
// ARR_REQ with ARR_DONE high, then drops ARR_DONE after ARR_REQ falls
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [R1] launched erase makes every byte of the chosen sectors read all ones
// [R2] software erases one to all sectors of one bank, never the test sector
// [R3] erase first programs the chosen sectors to zero on its own
// [R4] double-word program writes pair one over pair zero, ones to zeros only
// [R5] software aligns a double-word program address to an even word
// [R6] word program writes pair zero at the target address, ones to zeros only
// [R7] each selection bit clears itself when its operation completes
// [R8] pause halts program or erase, bank returns to read, busy flags clear
// [R9] during paused program only reads and program resume are accepted
// [R10] during paused erase reads, resume and unpausable programs are accepted
// [R11] resume means start bit again with the paused operation's selection bit
// [R12] software never launches a new operation while pause is set
// [R13] start bit launches operations and clears at end or pause
// [R14] start with error flag high is refused
// [R15] writing zero to the start bit does nothing
// [R16] sector register view follows module select: bank 2 or bank 0 bits
// [R17] software sets sector bits before launching an erase
// [R18] sector bits show state during erase, clear at clean end
// [R19] module select steers to secondary at 0, primary at 1, clears at end
// [R20] set sector bit means error if error flag, else paused if pause set
// [R21] busy bank reads give invalid data and trap, writes are ignored
// [R22] software sets exactly one selection bit with a new start
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
module fwo_ctrl (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic AVS_WAITREQUEST,
  output logic [31:0] AVS_READDATA,
  input wire logic ARR_DONE,
  input wire logic ARR_FAIL,
  output logic ARR_REQ,
  output logic ARR_HALT,
  output logic [2:0] ARR_STEP,
  output logic ARR_MODULE,
  output logic [9:0] ARR_SECTORS,
  output logic [23:0] ARR_ADDR,
  output logic [63:0] ARR_DATA,
  output logic [3:0] BANK_BUSY
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  fwo_pkg::fwo_state_t st_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic launch_r, pause_r, wpg_r, double_word_program_select_r, ser_r, module_select_r, err_r;
  logic pause_request_prg_r, pause_request_ers_r, ers_pre_r, nested_r, halted_r, fail_r;
  logic req_r, halt_r;
  logic [2:0] step_r;
  logic [9:0] sect_r;
  logic [23:0] addr_r;
  logic [31:0] d0_r, d1_r;
  logic [63:0] data_r;
  logic [3:0] busy_r;
  logic [1:0] sync_in, sync_out;
  logic done_s, fail_s;
  logic [9:0] b0_bits, sect_view;
  logic [2:0] b2_bits;

  ////////////////////////////////////////////////////////////////////////////
  // array handshake inputs come from the flash macro timing domain
  assign sync_in = {ARR_FAIL, ARR_DONE};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      fwo_sync3 u_sync (
        .clk(CLK_SYS),
        .nrst(NRST),
        .din(sync_in[gi]),
        .dout(sync_out[gi])
      );
    end
  endgenerate
  assign done_s = sync_out[0];
  assign fail_s = sync_out[1];

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: one wait cycle, the write lands when waitrequest is low
  wire req = AVS_READ | AVS_WRITE;
  wire wr = AVS_WRITE & ~wait_r;
  wire [31:0] bemask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                        {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  wire idle = (st_r == fwo_pkg::ST_IDLE);
  wire pause_request = pause_request_prg_r | pause_request_ers_r;
  wire [31:0] cmd_view = {16'h0000, launch_r, pause_r, wpg_r, double_word_program_select_r, ser_r,
                          3'h0, module_select_r, 7'h00};
  wire [31:0] stat_view = {21'h000000, pause_request_ers_r, pause_request_prg_r, err_r, 4'h0, busy_r};
  wire [31:0] wd_cmd = (cmd_view & ~bemask) | (AVS_WRITEDATA & bemask);
  wire [31:0] wd_sect = ({22'h000000, sect_view} & ~bemask) | (AVS_WRITEDATA & bemask);
  wire [31:0] wd_addr = ({8'h00, addr_r} & ~bemask) | (AVS_WRITEDATA & bemask);
  wire [31:0] wd_d0 = (d0_r & ~bemask) | (AVS_WRITEDATA & bemask);
  wire [31:0] wd_d1 = (d1_r & ~bemask) | (AVS_WRITEDATA & bemask);
  wire wr_cmd = wr & (AVS_ADDRESS == fwo_pkg::OFS_CMD);
  wire wr_stat = wr & (AVS_ADDRESS == fwo_pkg::OFS_STAT);
  // address and data stay frozen while an operation is running
  wire wr_lock_ok = wr & idle;
  wire wr_sect = wr_lock_ok & ~pause_request & (AVS_ADDRESS == fwo_pkg::OFS_SECT);
  wire wr_addr = wr_lock_ok & (AVS_ADDRESS == fwo_pkg::OFS_ADDR);
  wire wr_d0 = wr_lock_ok & (AVS_ADDRESS == fwo_pkg::OFS_DAT0);
  wire wr_d1 = wr_lock_ok & (AVS_ADDRESS == fwo_pkg::OFS_DAT1);
  wire [31:0] rmux =
    (AVS_ADDRESS == fwo_pkg::OFS_CMD) ? cmd_view :
    (AVS_ADDRESS == fwo_pkg::OFS_SECT) ? {22'h000000, sect_view} : // [R20]
    (AVS_ADDRESS == fwo_pkg::OFS_ADDR) ? {8'h00, addr_r} :
    (AVS_ADDRESS == fwo_pkg::OFS_DAT0) ? d0_r :
    (AVS_ADDRESS == fwo_pkg::OFS_DAT1) ? d1_r :
    (AVS_ADDRESS == fwo_pkg::OFS_STAT) ? stat_view : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // launch decode
  wire w_launch = wd_cmd[fwo_pkg::CMD_LAUNCH];
  wire w_pause = wd_cmd[fwo_pkg::CMD_PAUSE];
  wire w_wpg = wd_cmd[fwo_pkg::CMD_WPG];
  wire w_double_word_program_select = wd_cmd[fwo_pkg::CMD_DOUBLE_WORD_PROGRAM_SELECT];
  wire w_ser = wd_cmd[fwo_pkg::CMD_SER];
  wire w_module_select = wd_cmd[fwo_pkg::CMD_MODULE_SELECT];
  wire w_prog = w_wpg | w_double_word_program_select;
  wire go_new = ~pause_request & (w_ser | w_prog);
  wire go_prg_res = pause_request_prg_r & ~w_ser & (w_wpg == wpg_r) & (w_double_word_program_select == double_word_program_select_r); // [R9]
  wire go_nested = pause_request_ers_r & w_prog; // [R10]
  wire go_ers_res = pause_request_ers_r & w_ser & ~w_prog;
  // a start over a pending error or with pause set is simply not taken
  wire go = wr_cmd & idle & w_launch & ~err_r & ~w_pause & ~done_s & // [R14]
            (go_new | go_prg_res | go_nested | go_ers_res); // [R13]
  wire start_pre = go & ((go_new & w_ser) | (go_ers_res & ers_pre_r)); // [R3]
  wire start_ers = go & go_ers_res & ~ers_pre_r;
  wire bank_bit = addr_r[fwo_pkg::ADDR_BANK_BIT];
  wire [3:0] bank_ers = w_module_select ? fwo_pkg::BANK0 : fwo_pkg::BANK2;
  wire [3:0] bank_prg = w_module_select ? (bank_bit ? fwo_pkg::BANK1 : fwo_pkg::BANK0)
                               : (bank_bit ? fwo_pkg::BANK3 : fwo_pkg::BANK2);
  wire [9:0] sect_go = w_module_select ? b0_bits : {7'h00, b2_bits};
  wire [63:0] prg_data = w_double_word_program_select ? {d1_r, d0_r} : {fwo_pkg::ODD_KEEP, d0_r}; // [R4] [R6]

  ////////////////////////////////////////////////////////////////////////////
  // operation sequencing
  wire run = (st_r == fwo_pkg::ST_RUN);
  wire drain = (st_r == fwo_pkg::ST_DRAIN);
  wire halt_ok = run & pause_r & ~nested_r & ~done_s; // [R8] [R10]
  wire step_done = run & done_s;
  wire leave = drain & ~done_s;
  wire pause_end = leave & halted_r;
  wire pre_next = leave & ~halted_r & ~fail_r & (step_r == fwo_pkg::STEP_PRE); // [R1]
  wire op_end = leave & ~halted_r & ~pre_next;
  wire clr_sect = op_end & ~fail_r & ~nested_r; // [R18]
  wire sel_wr = wr_cmd & idle & (go | ~pause_request);

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
      st_r <= fwo_pkg::ST_IDLE;
    else if (go | pre_next)
      st_r <= fwo_pkg::ST_RUN;
    else if (step_done)
      st_r <= fwo_pkg::ST_DRAIN;
    else if (pause_end | op_end)
      st_r <= fwo_pkg::ST_IDLE;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      wait_r <= ~(req & wait_r);
      if (req & wait_r)
        rdata_r <= rmux;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
      launch_r <= fwo_pkg::CMD_RST[fwo_pkg::CMD_LAUNCH];
    else if (go)
      launch_r <= 1'b1; // [R13] [R15]
    else if (pause_end | op_end)
      launch_r <= 1'b0; // [R13]
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
      pause_r <= fwo_pkg::CMD_RST[fwo_pkg::CMD_PAUSE];
    else if (wr_cmd)
      pause_r <= w_pause;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      wpg_r <= fwo_pkg::CMD_RST[fwo_pkg::CMD_WPG];
      double_word_program_select_r <= fwo_pkg::CMD_RST[fwo_pkg::CMD_DOUBLE_WORD_PROGRAM_SELECT];
      ser_r <= fwo_pkg::CMD_RST[fwo_pkg::CMD_SER];
      module_select_r <= fwo_pkg::CMD_RST[fwo_pkg::CMD_MODULE_SELECT];
    end
    else if (op_end & nested_r)
    begin
      wpg_r <= 1'b0; // [R7]
      double_word_program_select_r <= 1'b0; // [R7]
    end
    else if (op_end)
    begin
      wpg_r <= 1'b0; // [R7]
      double_word_program_select_r <= 1'b0; // [R7]
      ser_r <= 1'b0; // [R7]
      module_select_r <= 1'b0; // [R19]
    end
    else if (sel_wr)
    begin
      wpg_r <= w_wpg;
      double_word_program_select_r <= w_double_word_program_select;
      ser_r <= go_nested ? ser_r : w_ser; // [R10]
      module_select_r <= w_module_select; // [R19]
    end
  end

  // a failure in the same cycle as a software clear wins
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
      err_r <= 1'b0;
    else if (op_end & fail_r)
      err_r <= 1'b1;
    else if (wr_stat & AVS_BYTEENABLE[1] & AVS_WRITEDATA[fwo_pkg::STAT_ERR])
      err_r <= 1'b0;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      pause_request_prg_r <= 1'b0;
      pause_request_ers_r <= 1'b0;
      ers_pre_r <= 1'b0;
      nested_r <= 1'b0;
    end
    else if (go)
    begin
      pause_request_prg_r <= 1'b0;
      pause_request_ers_r <= pause_request_ers_r & go_nested; // [R10]
      nested_r <= go_nested; // [R10]
    end
    else if (pause_end)
    begin
      pause_request_prg_r <= (step_r == fwo_pkg::STEP_PRG); // [R9]
      pause_request_ers_r <= (step_r != fwo_pkg::STEP_PRG); // [R10]
      ers_pre_r <= (step_r == fwo_pkg::STEP_PRE);
    end
    else if (op_end)
    begin
      pause_request_ers_r <= pause_request_ers_r & nested_r;
      nested_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      req_r <= 1'b0;
      halt_r <= 1'b0;
      halted_r <= 1'b0;
      fail_r <= 1'b0;
    end
    else
    begin
      req_r <= go | pre_next | (req_r & ~step_done);
      halt_r <= halt_ok | (halt_r & ~step_done); // [R8]
      if (step_done)
      begin
        halted_r <= halt_r;
        fail_r <= fail_s;
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      step_r <= fwo_pkg::STEP_NONE;
      sect_r <= fwo_pkg::SECT_RST;
      data_r <= {fwo_pkg::DAT_RST, fwo_pkg::DAT_RST};
    end
    else if (pre_next)
      step_r <= fwo_pkg::STEP_ERS; // [R1]
    else if (go)
    begin
      step_r <= start_pre ? fwo_pkg::STEP_PRE :
                start_ers ? fwo_pkg::STEP_ERS : fwo_pkg::STEP_PRG;
      sect_r <= sect_go; // [R16]
      data_r <= start_pre ? fwo_pkg::PRE_DATA : prg_data; // [R3] [R4] [R6]
    end
  end

  // busy banks tell the memory path to trap reads and drop writes
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
      busy_r <= 4'h0;
    else if (go)
      busy_r <= (start_pre | start_ers) ? bank_ers : bank_prg; // [R21]
    else if (pause_end | op_end)
      busy_r <= 4'h0; // [R8] [R21]
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      addr_r <= fwo_pkg::ADDR_RST;
      d0_r <= fwo_pkg::DAT_RST;
      d1_r <= fwo_pkg::DAT_RST;
    end
    else
    begin
      if (wr_addr)
        addr_r <= wd_addr[23:0];
      if (wr_d0)
        d0_r <= wd_d0;
      if (wr_d1)
        d1_r <= wd_d1;
    end
  end

  fwo_sector_reg u_sect (
    .clk(CLK_SYS),
    .nrst(NRST),
    .wr(wr_sect),
    .wdata(wd_sect[9:0]),
    .module_select(module_select_r),
    .clr(clr_sect),
    .bank0_sector_bits(b0_bits),
    .bank2_sector_bits(b2_bits),
    .view(sect_view)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign AVS_WAITREQUEST = wait_r;
  assign AVS_READDATA = rdata_r;
  assign ARR_REQ = req_r;
  assign ARR_HALT = halt_r;
  assign ARR_STEP = step_r;
  assign ARR_MODULE = module_select_r;
  assign ARR_SECTORS = sect_r;
  assign ARR_ADDR = addr_r;
  assign ARR_DATA = data_r;
  assign BANK_BUSY = busy_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  sequence s_pre_done;
    leave && !halted_r && !fail_r && step_r == fwo_pkg::STEP_PRE;
  endsequence
  sequence s_ers_issue;
    req_r && step_r == fwo_pkg::STEP_ERS;
  endsequence

  property p_pre_then_erase;
    s_pre_done |=> s_ers_issue;
  endproperty
  a_pre_then_erase: assert property (p_pre_then_erase) // [R1]
    else $error("erase step did not follow preconditioning");

  property p_precond_zero;
    $rose(req_r) && step_r == fwo_pkg::STEP_PRE |-> data_r == fwo_pkg::PRE_DATA;
  endproperty
  a_precond_zero: assert property (p_precond_zero) // [R3]
    else $error("preconditioning data not all zero");

  property p_dword_data;
    go && !start_pre && !start_ers && w_double_word_program_select |=> data_r == {d1_r, d0_r};
  endproperty
  a_dword_data: assert property (p_dword_data) // [R4]
    else $error("double word data wrong");

  property p_word_data;
    go && !start_pre && !start_ers && !w_double_word_program_select |=> data_r[31:0] == d0_r
      && data_r[63:32] == fwo_pkg::ODD_KEEP;
  endproperty
  a_word_data: assert property (p_word_data) // [R6]
    else $error("word data wrong");

  property p_sel_clear;
    op_end && !nested_r |=> !wpg_r && !double_word_program_select_r && !ser_r && !launch_r;
  endproperty
  a_sel_clear: assert property (p_sel_clear) // [R7]
    else $error("selection bits not cleared at end");

  property p_pause_release;
    pause_end |=> busy_r == 4'h0 && !launch_r && !req_r && (pause_request_prg_r || pause_request_ers_r);
  endproperty
  a_pause_release: assert property (p_pause_release) // [R8]
    else $error("pause did not release the bank");

  property p_prog_pause_reject;
    pause_request_prg_r && wr_cmd && idle && w_ser |=> st_r == fwo_pkg::ST_IDLE && !launch_r;
  endproperty
  a_prog_pause_reject: assert property (p_prog_pause_reject) // [R9]
    else $error("operation accepted during paused program");

  property p_nested_no_halt;
    nested_r |-> !halt_r;
  endproperty
  a_nested_no_halt: assert property (p_nested_no_halt) // [R10]
    else $error("nested program was halted");

  property p_err_refuse;
    wr_cmd && w_launch && err_r && idle |=> !launch_r ##1 !req_r;
  endproperty
  a_err_refuse: assert property (p_err_refuse) // [R14]
    else $error("start accepted with error flag high");

  property p_zero_write;
    wr_cmd && !w_launch && launch_r && run |=> launch_r;
  endproperty
  a_zero_write: assert property (p_zero_write) // [R15]
    else $error("writing zero cleared the start bit");

  property p_module_select_clear;
    op_end && !nested_r |=> !module_select_r && !ARR_MODULE;
  endproperty
  a_module_select_clear: assert property (p_module_select_clear) // [R19]
    else $error("module select not cleared at end");

  property p_sect_clear;
    clr_sect |=> b0_bits == fwo_pkg::SECT_RST && b2_bits == 3'h0;
  endproperty
  a_sect_clear: assert property (p_sect_clear) // [R18]
    else $error("sector bits not cleared at clean end");
endmodule

// ---- tb/test_fwo_ctrl.sv ----
// self-checking bench for fwo_ctrl: bus tasks, flash array responder, expectations
// assumes the array link handshake and register map of the design package
module test_fwo_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS = 1'b0;
  logic NRST = 1'b0;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'hf;
  logic ARR_DONE = 1'b0;
  logic ARR_FAIL = 1'b0;
  logic AVS_WAITREQUEST, ARR_REQ, ARR_HALT, ARR_MODULE;
  logic [31:0] AVS_READDATA;
  logic [2:0] ARR_STEP;
  logic [9:0] ARR_SECTORS;
  logic [23:0] ARR_ADDR;
  logic [63:0] ARR_DATA;
  logic [3:0] BANK_BUSY;
  int error_cnt = 0;
  int n_compared = 0;
  logic [31:0] rd, d0, d1;
  logic [23:0] ad;
  logic [9:0] sb, es;
  logic [3:0] be, bp;
  logic em;

  fwo_ctrl u_fwo_ctrl (
    .CLK_SYS(CLK_SYS),
    .NRST(NRST),
    .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .AVS_READDATA(AVS_READDATA),
    .ARR_DONE(ARR_DONE),
    .ARR_FAIL(ARR_FAIL),
    .ARR_REQ(ARR_REQ),
    .ARR_HALT(ARR_HALT),
    .ARR_STEP(ARR_STEP),
    .ARR_MODULE(ARR_MODULE),
    .ARR_SECTORS(ARR_SECTORS),
    .ARR_ADDR(ARR_ADDR),
    .ARR_DATA(ARR_DATA),
    .BANK_BUSY(BANK_BUSY)
  );

  initial
  begin
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task test_done;
    begin
      if (error_cnt == 0 && n_compared > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  task chk(input logic [63:0] g, input logic [63:0] e);
    begin
      n_compared++;
      if (g !== e)
      begin
        $display("[ERR] %0t got %h exp %h", $time, g, e);
        error_cnt++;
      end
    end
  endtask

  // sampled at the falling edge so the registered outputs are settled
  task automatic wfor(input bit halt, input logic v);
    int n;
    begin
      n = 0;
      @(negedge CLK_SYS);
      while ((halt ? ARR_HALT : ARR_REQ) !== v)
      begin
        n++;
        if (n > 300)
        begin
          error_cnt++;
          test_done();
        end
        @(negedge CLK_SYS);
      end
    end
  endtask

  // waitrequest and read data are taken at the rising edge, before that edge updates them
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge CLK_SYS);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_BYTEENABLE <= be;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      @(posedge CLK_SYS);
      while (AVS_WAITREQUEST !== 1'b0)
      begin
        n++;
        if (n > 300)
        begin
          error_cnt++;
          test_done();
        end
        @(posedge CLK_SYS);
      end
      rd = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(64'(rd & m), 64'(e));
    end
  endtask

  // plays the flash array for one step; the sync chain needs a few idle cycles after
  task arr(input logic [2:0] st, input logic [63:0] dt, input logic [3:0] bs, input logic fl);
    begin
      wfor(0, 1'b1);
      chk(64'(ARR_STEP), 64'(st));
      chk(64'(BANK_BUSY), 64'(bs));
      chk(64'(ARR_MODULE), 64'(em));
      if (st != fwo_pkg::STEP_ERS)
        chk(ARR_DATA, dt);
      if (st != fwo_pkg::STEP_PRG)
        chk(64'(ARR_SECTORS), 64'(es));
      @(posedge CLK_SYS);
      ARR_DONE <= 1'b1;
      ARR_FAIL <= fl;
      wfor(0, 1'b0);
      @(posedge CLK_SYS);
      ARR_DONE <= 1'b0;
      ARR_FAIL <= 1'b0;
      repeat (8) @(posedge CLK_SYS);
    end
  endtask

  initial
  begin
    repeat (90000) @(posedge CLK_SYS);
    error_cnt++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    be = 4'hf;
    void'($urandom(56));
    repeat (16) @(posedge CLK_SYS);
    NRST <= 1'b1;
    rdc(fwo_pkg::OFS_CMD, 32'hffff, 32'h0);
    rdc(fwo_pkg::OFS_DAT0, 32'hffffffff, 32'hffffffff);
    rdc(fwo_pkg::OFS_DAT1, 32'hffffffff, 32'hffffffff);
    rdc(fwo_pkg::OFS_SECT, 32'h3ff, 32'h0);
    wr(8'h3c, $urandom);
    rdc(8'h3c, 32'hffffffff, 32'h0);
    // sector view follows module select
    sb = 10'($urandom) | 10'h001;
    wr(fwo_pkg::OFS_CMD, 32'h0080);
    wr(fwo_pkg::OFS_SECT, 32'(sb));
    rdc(fwo_pkg::OFS_SECT, 32'h3ff, 32'(sb));
    wr(fwo_pkg::OFS_CMD, 32'h0);
    rdc(fwo_pkg::OFS_SECT, 32'h3ff, 32'h0);
    wr(fwo_pkg::OFS_SECT, 32'h5);
    rdc(fwo_pkg::OFS_SECT, 32'h7, 32'h5);
    wr(fwo_pkg::OFS_CMD, 32'h0080);
    rdc(fwo_pkg::OFS_SECT, 32'h3ff, 32'(sb));
    // clean erase on the primary module
    es = sb;
    em = 1'b1;
    wr(fwo_pkg::OFS_CMD, 32'h8880);
    arr(fwo_pkg::STEP_PRE, fwo_pkg::PRE_DATA, fwo_pkg::BANK0, 1'b0);
    arr(fwo_pkg::STEP_ERS, 64'h0, fwo_pkg::BANK0, 1'b0);
    rdc(fwo_pkg::OFS_CMD, 32'hffff, 32'h0);
    wr(fwo_pkg::OFS_CMD, 32'h0080);
    rdc(fwo_pkg::OFS_SECT, 32'h3ff, 32'h0);
    // word program; a zero write to the start bit must not disturb it
    ad = 24'($urandom) & 24'hfffff8;
    d0 = $urandom;
    bp = ad[17] ? fwo_pkg::BANK1 : fwo_pkg::BANK0;
    wr(fwo_pkg::OFS_ADDR, 32'(ad));
    wr(fwo_pkg::OFS_DAT0, d0);
    wr(fwo_pkg::OFS_CMD, 32'ha080);
    wfor(0, 1'b1);
    wr(fwo_pkg::OFS_CMD, 32'h0);
    rdc(fwo_pkg::OFS_CMD, 32'hffff, 32'ha080);
    rdc(fwo_pkg::OFS_STAT, 32'hf, 32'(bp));
    arr(fwo_pkg::STEP_PRG, {fwo_pkg::ODD_KEEP, d0}, bp, 1'b0);
    chk(64'(ARR_ADDR), 64'(ad));
    rdc(fwo_pkg::OFS_CMD, 32'hffff, 32'h0);
    // double word on the secondary module, odd word merged by byte lanes
    d1 = $urandom;
    d0 = $urandom;
    wr(fwo_pkg::OFS_DAT1, 32'hffffffff);
    be = 4'h3;
    wr(fwo_pkg::OFS_DAT1, d1);
    be = 4'hf;
    d1 = {16'hffff, d1[15:0]};
    wr(fwo_pkg::OFS_DAT0, d0);
    em = 1'b0;
    wr(fwo_pkg::OFS_CMD, 32'h9000);
    bp = ad[17] ? fwo_pkg::BANK3 : fwo_pkg::BANK2;
    arr(fwo_pkg::STEP_PRG, {d1, d0}, bp, 1'b0);
    rdc(fwo_pkg::OFS_CMD, 32'hffff, 32'h0);
    // failing erase keeps the sector bits and raises the error flag
    es = 10'h003;
    wr(fwo_pkg::OFS_SECT, 32'h3);
    wr(fwo_pkg::OFS_CMD, 32'h8800);
    arr(fwo_pkg::STEP_PRE, fwo_pkg::PRE_DATA, fwo_pkg::BANK2, 1'b0);
    arr(fwo_pkg::STEP_ERS, 64'h0, fwo_pkg::BANK2, 1'b1);
    rdc(fwo_pkg::OFS_STAT, 32'h7ff, 32'h100);
    rdc(fwo_pkg::OFS_SECT, 32'h7, 32'h3);
    // a start while the error flag is high is refused
    wr(fwo_pkg::OFS_CMD, 32'ha000);
    repeat (8) @(posedge CLK_SYS);
    chk(64'(ARR_REQ), 64'h0);
    rdc(fwo_pkg::OFS_CMD, 32'h8000, 32'h0);
    wr(fwo_pkg::OFS_STAT, 32'h100);
    rdc(fwo_pkg::OFS_STAT, 32'h100, 32'h0);
    // paused program refuses an erase, then resumes
    em = 1'b1;
    bp = ad[17] ? fwo_pkg::BANK1 : fwo_pkg::BANK0;
    wr(fwo_pkg::OFS_CMD, 32'ha080);
    wfor(0, 1'b1);
    wr(fwo_pkg::OFS_CMD, 32'h4000);
    wfor(1, 1'b1);
    arr(fwo_pkg::STEP_PRG, {fwo_pkg::ODD_KEEP, d0}, bp, 1'b0);
    rdc(fwo_pkg::OFS_STAT, 32'h7ff, 32'h200);
    rdc(fwo_pkg::OFS_CMD, 32'h8000, 32'h0);
    wr(fwo_pkg::OFS_CMD, 32'h8880);
    repeat (8) @(posedge CLK_SYS);
    chk(64'(ARR_REQ), 64'h0);
    wr(fwo_pkg::OFS_CMD, 32'ha080);
    arr(fwo_pkg::STEP_PRG, {fwo_pkg::ODD_KEEP, d0}, bp, 1'b0);
    rdc(fwo_pkg::OFS_CMD, 32'hffff, 32'h0);
    rdc(fwo_pkg::OFS_STAT, 32'h60f, 32'h0);
    // paused erase takes a program that cannot be paused, then resumes
    em = 1'b0;
    wr(fwo_pkg::OFS_SECT, 32'h3);
    wr(fwo_pkg::OFS_CMD, 32'h8800);
    wfor(0, 1'b1);
    wr(fwo_pkg::OFS_CMD, 32'h4000);
    wfor(1, 1'b1);
    arr(fwo_pkg::STEP_PRE, fwo_pkg::PRE_DATA, fwo_pkg::BANK2, 1'b0);
    rdc(fwo_pkg::OFS_STAT, 32'h7ff, 32'h400);
    rdc(fwo_pkg::OFS_SECT, 32'h7, 32'h3);
    bp = ad[17] ? fwo_pkg::BANK3 : fwo_pkg::BANK2;
    wr(fwo_pkg::OFS_CMD, 32'ha000);
    wfor(0, 1'b1);
    wr(fwo_pkg::OFS_CMD, 32'h4000);
    repeat (8) @(posedge CLK_SYS);
    chk(64'(ARR_HALT), 64'h0);
    arr(fwo_pkg::STEP_PRG, {fwo_pkg::ODD_KEEP, d0}, bp, 1'b0);
    rdc(fwo_pkg::OFS_CMD, 32'ha800, 32'h0800);
    wr(fwo_pkg::OFS_CMD, 32'h8800);
    arr(fwo_pkg::STEP_PRE, fwo_pkg::PRE_DATA, fwo_pkg::BANK2, 1'b0);
    arr(fwo_pkg::STEP_ERS, 64'h0, fwo_pkg::BANK2, 1'b0);
    rdc(fwo_pkg::OFS_CMD, 32'hffff, 32'h0);
    rdc(fwo_pkg::OFS_STAT, 32'h7ff, 32'h0);
    test_done();
  end
endmodule
